/* logic/user_output_select.sv */
/*
 * Two user-configurable output pins of one transceiver, their two control
 * registers, and the alternate receive-input formats they enable.
 * Assumes status sources arrive on clk_i; line pins are asynchronous.
 */
// What this block does
// - Two output pins can each show a clock, an alarm, a static level or transmit data.
// - Bits 3 to 0 of each pin's own control register choose that pin's function.
// - For a clock or alarm, bit 4 at one gives active high and at zero active low.
// - With the select field all zero, each pin drives the level of its own bit 4.
// - Bit 7 of the first register makes the line inputs TTL positive and negative rails.
// - Bit 6 of the first register inverts coded-mark input data when set.
// - Bit 5 of the first register enables coded-mark line code when set.
// - Bit 7 of the second register turns the line inputs into NRZ data and its clock.
// - Slip selection pulses once per slip; CRC selection pulses per bad multiframe, held inactive on sync loss.
// - Data-tap selection: second pin carries transmit NRZ, first pin received serial data.
// - Encoded-transmit selection: first pin negative rail, second pin positive rail.
// - Pattern-error selection emits a pulse for each received test-pattern bit error.
`timescale 1ns/10ps
module user_output_select (
    input  wire logic                        clk_i,                   // Master clock
    input  wire logic                        rst_b_i,                 // Async reset, low
    input  wire logic [7:0]                  reg_addr_i,              // Register address
    input  wire logic                        reg_wr_i,                // Write strobe
    input  wire logic                        reg_rd_i,                // Read strobe
    input  wire logic [7:0]                  reg_wdata_i,             // Write data
    output logic      [7:0]                  reg_rdata_o,             // Read data
    input  user_output_pkg::line_status_s    status_i,                // Routable sources
    input  wire logic                        receive_line_positive_i, // Positive line pin
    input  wire logic                        receive_line_negative_i, // Negative line pin
    output user_output_pkg::rx_line_s        rx_line_o,               // Formatted rx data
    output logic                             first_user_pin_o,        // First user pin
    output logic                             second_user_pin_o        // Second user pin
);

    user_output_pkg::pin_ctrl_s ctrl_reg [2];
    logic [7:0]                 rdata_reg;
    logic [1:0]                 pin_out;

    // Control registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_reg[0] <= user_output_pkg::pin_ctrl_s'(
                user_output_pkg::PIN_CONTROL_RESET);
            ctrl_reg[1] <= user_output_pkg::pin_ctrl_s'(
                user_output_pkg::PIN_CONTROL_RESET);
        end else if (reg_wr_i) begin
            if (reg_addr_i == user_output_pkg::FIRST_PIN_CONTROL_ADDR) begin
                ctrl_reg[0] <= user_output_pkg::pin_ctrl_s'(reg_wdata_i);
            end
            if (reg_addr_i == user_output_pkg::SECOND_PIN_CONTROL_ADDR) begin
                ctrl_reg[1] <= user_output_pkg::pin_ctrl_s'(reg_wdata_i);
            end
        end
    end

    // Read data, zero for unmapped addresses
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_reg <= user_output_pkg::READ_IDLE_VALUE;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                user_output_pkg::FIRST_PIN_CONTROL_ADDR:  rdata_reg <= ctrl_reg[0];
                user_output_pkg::SECOND_PIN_CONTROL_ADDR: rdata_reg <= ctrl_reg[1];
                default: rdata_reg <= user_output_pkg::READ_IDLE_VALUE;
            endcase
        end
    end

    assign reg_rdata_o = rdata_reg;

    // Per-pin source selection
    for (genvar g = 0; g < 2; g++) begin : g_pin
        logic src;
        logic is_tap;
        logic pin_next;
        logic pin_reg;

        always_comb begin
            src    = 1'b0;
            is_tap = 1'b0;
            case (ctrl_reg[g].select)
                user_output_pkg::SEL_STATIC:        src = 1'b0;
                user_output_pkg::SEL_RX_CLOCK:      src = status_i.rx_clock;
                user_output_pkg::SEL_LOSS_SYNC:     src = status_i.loss_sync;
                user_output_pkg::SEL_LOSS_CARRIER:  src = status_i.loss_carrier;
                user_output_pkg::SEL_REMOTE_ALARM:  src = status_i.remote_alarm;
                user_output_pkg::SEL_ALL_ONES:      src = status_i.all_ones;
                user_output_pkg::SEL_SLIP:          src = status_i.slip;
                user_output_pkg::SEL_CRC_ERROR:
                    src = status_i.crc_error && !status_i.loss_sync;
                user_output_pkg::SEL_LOSS_TX_CLOCK: src = status_i.loss_tx_clock;
                user_output_pkg::SEL_FRAME_SYNC:    src = status_i.frame_sync;
                user_output_pkg::SEL_PRBS_ERROR:    src = status_i.prbs_error;
                user_output_pkg::SEL_DATA_TAP: begin
                    is_tap = 1'b1;
                    src    = (g == 0) ? status_i.rx_serial : status_i.tx_nrz;
                end
                user_output_pkg::SEL_CRC4_MF_SYNC:  src = status_i.crc4_mf_sync;
                user_output_pkg::SEL_CAS_MF_SYNC:   src = status_i.cas_mf_sync;
                user_output_pkg::SEL_CURRENT_LIMIT: src = status_i.current_limit;
                user_output_pkg::SEL_TX_RAILS: begin
                    is_tap = 1'b1;
                    src    = (g == 0) ? status_i.transmit_negative_rail
                                      : status_i.transmit_positive_rail;
                end
                default:                            src = 1'b0;
            endcase
            if (ctrl_reg[g].select == user_output_pkg::SEL_STATIC) begin
                pin_next = ctrl_reg[g].level_invert;
            end else if (is_tap) begin
                pin_next = src;
            end else begin
                pin_next = ctrl_reg[g].level_invert ? src : !src;
            end
        end

        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                pin_reg <= 1'b0;
            end else begin
                pin_reg <= pin_next;
            end
        end

        assign pin_out[g] = pin_reg;
    end

    assign first_user_pin_o  = pin_out[0];
    assign second_user_pin_o = pin_out[1];

    // Alternate receive-input formats; second register bits 6 and 5 are unused
    line_input_format u_line_input_format (
        .clk_i                            (clk_i),
        .rst_b_i                          (rst_b_i),
        .receive_line_positive_i          (receive_line_positive_i),
        .receive_line_negative_i          (receive_line_negative_i),
        .ttl_rail_input_enable_i          (ctrl_reg[0].high_enable),
        .coded_mark_enable_i              (ctrl_reg[0].cmi_enable),
        .coded_mark_input_invert_i        (ctrl_reg[0].cmi_invert),
        .clocked_nonreturn_input_enable_i (ctrl_reg[1].high_enable),
        .rx_line_o                        (rx_line_o)
    );

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_write_first;
        reg_wr_i && reg_addr_i == user_output_pkg::FIRST_PIN_CONTROL_ADDR
            ##1 reg_rd_i && reg_addr_i == user_output_pkg::FIRST_PIN_CONTROL_ADDR && !reg_wr_i
            |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    a_write_first: assert property (p_write_first)
        else $error("first control readback differs from write");

    property p_static_level;
        ctrl_reg[1].select == user_output_pkg::SEL_STATIC
            |=> second_user_pin_o == $past(ctrl_reg[1].level_invert);
    endproperty
    a_static_level: assert property (p_static_level)
        else $error("static pin level wrong");

    property p_clock_polarity;
        ctrl_reg[0].select == user_output_pkg::SEL_RX_CLOCK
            |=> first_user_pin_o == ($past(ctrl_reg[0].level_invert) ~^ $past(status_i.rx_clock));
    endproperty
    a_clock_polarity: assert property (p_clock_polarity)
        else $error("clock polarity wrong");

    property p_crc_lost_sync;
        ctrl_reg[0].select == user_output_pkg::SEL_CRC_ERROR && status_i.loss_sync
            |=> first_user_pin_o == !$past(ctrl_reg[0].level_invert);
    endproperty
    a_crc_lost_sync: assert property (p_crc_lost_sync)
        else $error("crc error not held inactive during sync loss");

    property p_slip_pulse;
        ctrl_reg[1].select == user_output_pkg::SEL_SLIP && ctrl_reg[1].level_invert
            && status_i.slip ##1 !status_i.slip && $stable(ctrl_reg[1])
            |-> second_user_pin_o ##1 !second_user_pin_o;
    endproperty
    a_slip_pulse: assert property (p_slip_pulse)
        else $error("slip pulse not one clock");

    property p_data_tap;
        ctrl_reg[0].select == user_output_pkg::SEL_DATA_TAP
            && ctrl_reg[1].select == user_output_pkg::SEL_DATA_TAP
            |=> first_user_pin_o == $past(status_i.rx_serial)
                && second_user_pin_o == $past(status_i.tx_nrz);
    endproperty
    a_data_tap: assert property (p_data_tap)
        else $error("data tap routing wrong");

    property p_tx_rails;
        ctrl_reg[0].select == user_output_pkg::SEL_TX_RAILS
            && ctrl_reg[1].select == user_output_pkg::SEL_TX_RAILS
            |=> first_user_pin_o == $past(status_i.transmit_negative_rail)
                && second_user_pin_o == $past(status_i.transmit_positive_rail);
    endproperty
    a_tx_rails: assert property (p_tx_rails)
        else $error("encoded rail routing wrong");

    property p_prbs_error;
        ctrl_reg[1].select == user_output_pkg::SEL_PRBS_ERROR && ctrl_reg[1].level_invert
            |=> second_user_pin_o == $past(status_i.prbs_error);
    endproperty
    a_prbs_error: assert property (p_prbs_error)
        else $error("pattern error pulse missing");

    property p_ttl_rails;
        ctrl_reg[0].high_enable && !ctrl_reg[1].high_enable && $stable(ctrl_reg[0])
            && $stable(ctrl_reg[1])
            |=> rx_line_o.valid;
    endproperty
    a_ttl_rails: assert property (p_ttl_rails)
        else $error("ttl rail data not valid every clock");

    c_static_high: cover property (ctrl_reg[0].select == user_output_pkg::SEL_STATIC
        && ctrl_reg[0].level_invert ##1 first_user_pin_o);
    c_nrz_sample: cover property (ctrl_reg[1].high_enable && rx_line_o.valid);
    c_crc_pulse: cover property (ctrl_reg[0].select == user_output_pkg::SEL_CRC_ERROR
        && status_i.crc_error && !status_i.loss_sync);

endmodule

/* logic/user_output_pkg.sv */
/*
 * Constants and types for the user-configurable output pins and the
 * alternate receive-input formats of one transceiver.
 * Assumes one master clock and an 8-bit register port.
 */
package user_output_pkg;

    // Register offsets on the register port
    localparam logic [7:0] FIRST_PIN_CONTROL_ADDR  = 8'h1a;
    localparam logic [7:0] SECOND_PIN_CONTROL_ADDR = 8'h1b;

    // Values after reset
    localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE_VALUE   = 8'h00;

    // Field positions inside a control register
    localparam int HIGH_ENABLE_BIT = 7;
    localparam int CMI_INVERT_BIT  = 6;
    localparam int CMI_ENABLE_BIT  = 5;
    localparam int LEVEL_BIT       = 4;
    localparam int SELECT_LSB      = 0;
    localparam int SELECT_WIDTH    = 4;

    typedef enum logic [3:0] {
        SEL_STATIC        = 4'h0,
        SEL_RX_CLOCK      = 4'h1,
        SEL_LOSS_SYNC     = 4'h2,
        SEL_LOSS_CARRIER  = 4'h3,
        SEL_REMOTE_ALARM  = 4'h4,
        SEL_ALL_ONES      = 4'h5,
        SEL_SLIP          = 4'h6,
        SEL_CRC_ERROR     = 4'h7,
        SEL_LOSS_TX_CLOCK = 4'h8,
        SEL_FRAME_SYNC    = 4'h9,
        SEL_PRBS_ERROR    = 4'ha,
        SEL_DATA_TAP      = 4'hb,
        SEL_CRC4_MF_SYNC  = 4'hc,
        SEL_CAS_MF_SYNC   = 4'hd,
        SEL_CURRENT_LIMIT = 4'he,
        SEL_TX_RAILS      = 4'hf
    } pin_select_e;

    // Bit 7 is ttl_rail_input_enable (first) or clocked_nonreturn_input_enable
    // (second); bits 6 and 5 are the coded-mark controls (first only)
    typedef struct packed {
        logic        high_enable;
        logic        cmi_invert;
        logic        cmi_enable;
        logic        level_invert;
        pin_select_e select;
    } pin_ctrl_s;

    // Sources that may be routed to the pins, all on the master clock
    typedef struct packed {
        logic rx_clock;
        logic loss_sync;
        logic loss_carrier;
        logic remote_alarm;
        logic all_ones;
        logic slip;
        logic crc_error;
        logic loss_tx_clock;
        logic frame_sync;
        logic prbs_error;
        logic crc4_mf_sync;
        logic cas_mf_sync;
        logic current_limit;
        logic rx_serial;
        logic tx_nrz;
        logic transmit_positive_rail;
        logic transmit_negative_rail;
    } line_status_s;

    // Formatted receive data handed to the receiver
    typedef struct packed {
        logic positive;
        logic negative;
        logic valid;
    } rx_line_s;

endpackage

/* logic/line_input_format.sv */
/*
 * Receive-input format selection: normal rails, TTL rails, coded-mark
 * data with optional inversion, or NRZ data with a clock on the negative line.
 * Assumes the line pins are asynchronous to clk_i.
 */
`timescale 1ns/10ps
module line_input_format (
    input  wire logic                       clk_i,                  // Master clock
    input  wire logic                       rst_b_i,                // Async reset, low
    input  wire logic                       receive_line_positive_i, // Positive line pin
    input  wire logic                       receive_line_negative_i, // Negative line pin
    input  wire logic                       ttl_rail_input_enable_i, // TTL rail mode
    input  wire logic                       coded_mark_enable_i,    // CMI mode
    input  wire logic                       coded_mark_input_invert_i, // CMI inversion
    input  wire logic                       clocked_nonreturn_input_enable_i, // NRZ mode
    output user_output_pkg::rx_line_s       rx_line_o               // Formatted data
);

    logic pos_meta_reg;
    logic pos_sync_reg;
    logic neg_meta_reg;
    logic neg_sync_reg;
    logic neg_prev_reg;
    user_output_pkg::rx_line_s line_reg;

    // Two-stage synchronisers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pos_meta_reg <= 1'b0;
            pos_sync_reg <= 1'b0;
            neg_meta_reg <= 1'b0;
            neg_sync_reg <= 1'b0;
            neg_prev_reg <= 1'b0;
        end else begin
            pos_meta_reg <= receive_line_positive_i;
            pos_sync_reg <= pos_meta_reg;
            neg_meta_reg <= receive_line_negative_i;
            neg_sync_reg <= neg_meta_reg;
            neg_prev_reg <= neg_sync_reg;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            line_reg <= '0;
        end else if (clocked_nonreturn_input_enable_i) begin
            // Data taken on the falling edge of the negative-line clock
            line_reg.positive <= (neg_prev_reg && !neg_sync_reg) ? pos_sync_reg
                                                                 : line_reg.positive;
            line_reg.negative <= 1'b0;
            line_reg.valid    <= neg_prev_reg && !neg_sync_reg;
        end else if (ttl_rail_input_enable_i) begin
            line_reg.positive <= pos_sync_reg;
            line_reg.negative <= neg_sync_reg;
            line_reg.valid    <= 1'b1;
        end else if (coded_mark_enable_i) begin
            line_reg.positive <= pos_sync_reg ^ coded_mark_input_invert_i;
            line_reg.negative <= 1'b0;
            line_reg.valid    <= 1'b1;
        end else begin
            line_reg.positive <= pos_sync_reg;
            line_reg.negative <= neg_sync_reg;
            line_reg.valid    <= 1'b1;
        end
    end

    assign rx_line_o = line_reg;

endmodule

/* dv/line_source_model.sv */
/*
 * Behavioural source for the two receive line pins: static rails, or
 * NRZ data with its clock on the negative line.
 * Assumes the bench calls its tasks just after a falling clk_i edge.
 */
`timescale 1ns/10ps
module line_source_model (
    output logic positive_o, // Positive line pin
    output logic negative_o  // Negative line pin
);
    initial begin
        positive_o = 1'b0;
        negative_o = 1'b1;
    end

    task automatic set_rails(input logic p, input logic n);
        positive_o = p;
        negative_o = n;
    endtask

    // Msb first, 80 ns bit clock; data changes only while the clock is high
    task automatic send_nrz(input logic [7:0] value);
        for (int i = 7; i >= 0; i--) begin
            negative_o = 1'b1;
            positive_o = value[i];
            #40;
            negative_o = 1'b0;
            #40;
        end
        negative_o = 1'b1;
        #40;
        // Data line no longer valid once the frame ends
        positive_o = ~value[0];
    endtask
endmodule

/* dv/testbench.sv */
/*
 * Self-checking bench for user_output_select: register port, pin routing,
 * pulse selections, receive-input formats and reset.
 * Assumes line_source_model drives the receive line pins.
 */
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        logic [7:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic [16:0] status;
        logic [1:0]  pins;
    } row_s;

    logic                          clk_i       = 1'b0;
    logic                          rst_b_i     = 1'b0;
    logic [7:0]                    reg_addr_i  = 8'h00;
    logic                          reg_wr_i    = 1'b0;
    logic                          reg_rd_i    = 1'b0;
    logic [7:0]                    reg_wdata_i = 8'h00;
    logic [7:0]                    reg_rdata_o;
    user_output_pkg::line_status_s status_i    = '0;
    logic                          rx_pos;
    logic                          rx_neg;
    user_output_pkg::rx_line_s     rx_line_o;
    logic                          first_user_pin_o;
    logic                          second_user_pin_o;
    int                            errors      = 0;
    int                            checks_done = 0;
    int                            n;
    logic [7:0]                    got;
    // Pin expectations: {first, second}
    row_s rows [24] = '{
        '{8'h00, 8'h00, 17'h1ffff, 2'b00}, '{8'h10, 8'h10, 17'h00000, 2'b11},
        '{8'h11, 8'h11, 17'h10000, 2'b11}, '{8'h01, 8'h01, 17'h10000, 2'b00},
        '{8'h12, 8'h12, 17'h08000, 2'b11}, '{8'h13, 8'h13, 17'h04000, 2'b11},
        '{8'h04, 8'h04, 17'h02000, 2'b00}, '{8'h15, 8'h15, 17'h01000, 2'b11},
        '{8'h16, 8'h16, 17'h00800, 2'b11}, '{8'h17, 8'h17, 17'h00400, 2'b11},
        '{8'h17, 8'h17, 17'h08400, 2'b00}, '{8'h07, 8'h07, 17'h08400, 2'b11},
        '{8'h18, 8'h18, 17'h00200, 2'b11}, '{8'h19, 8'h19, 17'h00100, 2'b11},
        '{8'h1a, 8'h1a, 17'h00080, 2'b11}, '{8'h1c, 8'h1c, 17'h00040, 2'b11},
        '{8'h1d, 8'h1d, 17'h00020, 2'b11}, '{8'h0e, 8'h0e, 17'h00010, 2'b00},
        '{8'h1b, 8'h1b, 17'h00008, 2'b10}, '{8'h0b, 8'h0b, 17'h00004, 2'b01},
        '{8'h1f, 8'h1f, 17'h00002, 2'b01}, '{8'h0f, 8'h0f, 17'h00001, 2'b10},
        '{8'h11, 8'h10, 17'h00000, 2'b01}, '{8'h01, 8'h11, 17'h10000, 2'b01}
    };

    always #5 clk_i = ~clk_i;

    line_source_model src (
        .positive_o (rx_pos),
        .negative_o (rx_neg)
    );

    user_output_select dut (
        .clk_i                   (clk_i),
        .rst_b_i                 (rst_b_i),
        .reg_addr_i              (reg_addr_i),
        .reg_wr_i                (reg_wr_i),
        .reg_rd_i                (reg_rd_i),
        .reg_wdata_i             (reg_wdata_i),
        .reg_rdata_o             (reg_rdata_o),
        .status_i                (status_i),
        .receive_line_positive_i (rx_pos),
        .receive_line_negative_i (rx_neg),
        .rx_line_o               (rx_line_o),
        .first_user_pin_o        (first_user_pin_o),
        .second_user_pin_o       (second_user_pin_o)
    );

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        reg_addr_i  = addr;
        reg_wdata_i = data;
        reg_wr_i    = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_i);
        reg_addr_i = addr;
        reg_rd_i   = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        @(negedge clk_i);
        data = reg_rdata_o;
    endtask

    // Program the first register, set the rails, compare {positive, negative}
    task automatic rx_case(input logic [7:0] ctrl, input logic p, input logic n,
                           input logic [1:0] exp);
        reg_write(8'h1a, ctrl);
        src.set_rails(p, n);
        repeat (6) @(negedge clk_i);
        check("rx rails", {6'h00, rx_line_o.positive, rx_line_o.negative}, {6'h00, exp});
    endtask

    task automatic complete_run;
        $display("Checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #500000;
        errors++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        rst_b_i = 1'b1;
        check("pins after reset", {6'h00, first_user_pin_o, second_user_pin_o}, 8'h00);
        reg_read(8'h1a, got);
        check("first control reset", got, 8'h00);
        reg_read(8'h1b, got);
        check("second control reset", got, 8'h00);
        foreach (rows[i]) begin
            reg_write(8'h1a, rows[i].ctrl_a);
            reg_write(8'h1b, rows[i].ctrl_b);
            reg_read(8'h1b, got);
            check("second control", got, rows[i].ctrl_b);
            status_i = rows[i].status;
            repeat (2) @(negedge clk_i);
            check("pins", {6'h00, first_user_pin_o, second_user_pin_o},
                  {6'h00, rows[i].pins});
        end
        // Single-cycle slip gives a single-cycle pin pulse
        reg_write(8'h1a, 8'h16);
        reg_write(8'h1b, 8'h16);
        status_i = '0;
        @(negedge clk_i);
        status_i.slip = 1'b1;
        @(negedge clk_i);
        status_i.slip = 1'b0;
        check("slip pulse", {6'h00, first_user_pin_o, second_user_pin_o}, 8'h03);
        @(negedge clk_i);
        check("slip pulse end", {6'h00, first_user_pin_o, second_user_pin_o}, 8'h00);
        // Unmapped address: write ignored, read gives zero
        reg_write(8'h1c, 8'hff);
        reg_read(8'h1a, got);
        check("first control kept", got, 8'h16);
        reg_read(8'h1c, got);
        check("unmapped read", got, 8'h00);
        // Write then read in the very next cycle returns the new value
        @(negedge clk_i);
        reg_addr_i  = 8'h1a;
        reg_wdata_i = 8'h15;
        reg_wr_i    = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        check("back to back read", reg_rdata_o, 8'h15);
        rx_case(8'h00, 1'b0, 1'b1, 2'b01);
        rx_case(8'h80, 1'b1, 1'b0, 2'b10);
        check("ttl valid", {7'h00, rx_line_o.valid}, 8'h01);
        rx_case(8'h80, 1'b0, 1'b1, 2'b01);
        rx_case(8'h20, 1'b1, 1'b1, 2'b10);
        rx_case(8'h60, 1'b1, 1'b1, 2'b00);
        rx_case(8'h60, 1'b0, 1'b1, 2'b10);
        // NRZ takes priority over TTL rails
        rx_case(8'h80, 1'b0, 1'b1, 2'b01);
        reg_write(8'h1b, 8'h80);
        repeat (4) @(negedge clk_i);
        got = 8'h00;
        n = 0;
        fork
            src.send_nrz(8'ha6);
            for (int c = 0; c < 120; c++) begin
                @(negedge clk_i);
                if (rx_line_o.valid === 1'b1) begin
                    got = {got[6:0], rx_line_o.positive};
                    n++;
                end
            end
        join
        check("nrz bit count", n[7:0], 8'h08);
        check("nrz data", got, 8'ha6);
        // Reset in mid-run clears both registers and the pins
        reg_write(8'h1a, 8'h10);
        reg_write(8'h1b, 8'h10);
        repeat (2) @(negedge clk_i);
        check("pins high", {6'h00, first_user_pin_o, second_user_pin_o}, 8'h03);
        rst_b_i = 1'b0;
        @(negedge clk_i);
        check("pins in reset", {6'h00, first_user_pin_o, second_user_pin_o}, 8'h00);
        rst_b_i = 1'b1;
        reg_read(8'h1b, got);
        check("second control cleared", got, 8'h00);
        complete_run();
    end
endmodule
